/* File: rtl/usspi_regs.vh */
// register map, field positions and reset values of the serial port
`ifndef USSPI_REGS_VH
`define USSPI_REGS_VH

`define USSPI_ADDR_W 8
`define USSPI_OFS_DATA 8'h08
`define USSPI_OFS_BAUD_LO 8'h09
`define USSPI_OFS_BAUD_HI 8'h0a
`define USSPI_OFS_SDCTRL 8'h0b
`define USSPI_OFS_CTRL_C 8'h0c
`define USSPI_OFS_CTRL_B 8'h0d
`define USSPI_OFS_STAT_A 8'h0e

// start_detect_control fields
`define USSPI_SD_RECEIVE_START_IRQ_ENABLE 7
`define USSPI_SD_RXS 6
`define USSPI_SD_START_FRAME_DETECT_ENABLE 5
// control C fields
`define USSPI_C_MODE_HI 7
`define USSPI_C_MODE_LO 6
`define USSPI_C_DORD 2
`define USSPI_C_CPHA 1
`define USSPI_C_CPOL 0
// control B fields
`define USSPI_B_RXCIE 7
`define USSPI_B_TXCIE 6
`define USSPI_B_UDRIE 5
`define USSPI_B_RXEN 4
`define USSPI_B_TXEN 3
// status A fields
`define USSPI_A_RXC 7
`define USSPI_A_TXC 6
`define USSPI_A_UDRE 5

`define USSPI_MODE_ASYNC 2'h0
`define USSPI_MODE_SYNC 2'h1
`define USSPI_MODE_MSPI 2'h3

`define USSPI_RST_BAUD 12'h000
`define USSPI_RST_SDCTRL 8'h00
`define USSPI_RST_CTRL_C 8'h06
`define USSPI_RST_CTRL_B 8'h00

`define USSPI_EDGES 4'hf
`define USSPI_RX_DEPTH 2

`endif

/* File: rtl/usspi_baud.v */
// bit-rate prescaler producing half-period ticks of the transfer clock
`timescale 1ns/1ns
`default_nettype none
module usspi_baud (
  input wire CLK, // system clock
  input wire RESET_N, // asynchronous reset, active low
  input wire CE, // clock enable
  input wire RUN, // count while high
  input wire RELOAD, // restart count from divisor
  input wire [11:0] DIVISOR, // divisor value
  output reg TICK // one-cycle pulse every divisor+1 cycles
);

  reg [11:0] cnt_q;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_q <= 12'h000;
      TICK <= 1'b0;
    end else if (CE) begin
      if (RELOAD || !RUN) begin
        cnt_q <= DIVISOR;
        TICK <= 1'b0;
      end else if (cnt_q == 12'h000) begin
        cnt_q <= DIVISOR;
        TICK <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 12'h001;
        TICK <= 1'b0;
      end
    end
  end

endmodule // usspi_baud
`default_nettype wire

/* File: rtl/usspi_core.v */
// serial port core: register file, start detector and SPI/sync shifter
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "usspi_regs.vh"
module usspi_core (
  input wire CLK, // system clock, 100 MHz
  input wire RESET_N, // asynchronous reset, active low
  input wire CE, // clock enable, freezes all state when low
  input wire [7:0] ADDR, // register address
  input wire [7:0] WDATA, // write data
  input wire WR, // write strobe
  input wire RD, // read strobe
  output reg [7:0] RDATA, // read data, valid the cycle after RD
  input wire GIE, // global interrupt enable
  input wire XCK_DIR, // transfer clock pin direction, 1 = output
  output wire XCK_O, // transfer clock out
  output wire XCK_OE_N, // transfer clock output enable, low drives
  output wire TXD, // serial data out
  input wire RXD, // serial data in
  output wire IRQ_RX_START, // receive-start interrupt request
  output wire IRQ_RX_DONE, // receive-complete interrupt request
  output wire IRQ_TX_DONE, // transmit-complete interrupt request
  output wire IRQ_DATA_EMPTY, // data register empty interrupt request
  output wire WAKE // wake request to the sleep controller
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;

  reg [11:0] baud_q;
  reg [7:0] sdctrl_q;
  reg [7:0] ctrl_c_q;
  reg [7:0] ctrl_b_q;
  reg [1:0] state_q;
  reg [7:0] txbuf_q;
  reg txfull_q;
  reg [7:0] tx_sh_q;
  reg [7:0] rx_sh_q;
  reg [3:0] edge_q;
  reg sck_q;
  reg txd_q;
  reg txc_q;
  reg rxs_q;
  reg rxd_prev_q;
  reg [7:0] rxbuf_q [0:`USSPI_RX_DEPTH-1];
  reg rd_ptr_q;
  reg wr_ptr_q;
  reg [1:0] rx_cnt_q;
  wire tick;

  wire [1:0] mode = ctrl_c_q[`USSPI_C_MODE_HI:`USSPI_C_MODE_LO];
  wire mspi = (mode == `USSPI_MODE_MSPI);
  wire sync = (mode == `USSPI_MODE_SYNC);
  wire cpol = ctrl_c_q[`USSPI_C_CPOL];
  // synchronous mode fixes LSB first and setup on the polarity edge
  wire cpha = mspi ? ctrl_c_q[`USSPI_C_CPHA] : 1'b1;
  wire dord = mspi ? ctrl_c_q[`USSPI_C_DORD] : 1'b1;
  wire txen = ctrl_b_q[`USSPI_B_TXEN];
  wire rxen = ctrl_b_q[`USSPI_B_RXEN];
  wire receive_start_irq_enable = sdctrl_q[`USSPI_SD_RECEIVE_START_IRQ_ENABLE];
  wire start_frame_detect_enable = sdctrl_q[`USSPI_SD_START_FRAME_DETECT_ENABLE];
  wire receive_complete_flag = (rx_cnt_q != 2'h0);

  wire wr_data = WR && (ADDR == `USSPI_OFS_DATA);
  wire wr_blo = WR && (ADDR == `USSPI_OFS_BAUD_LO);
  wire wr_bhi = WR && (ADDR == `USSPI_OFS_BAUD_HI);
  wire wr_sd = WR && (ADDR == `USSPI_OFS_SDCTRL);
  wire wr_c = WR && (ADDR == `USSPI_OFS_CTRL_C);
  wire wr_b = WR && (ADDR == `USSPI_OFS_CTRL_B);
  wire wr_a = WR && (ADDR == `USSPI_OFS_STAT_A);
  wire rd_data = RD && (ADDR == `USSPI_OFS_DATA);

  ////////////////////////////////////////////////////////////////////////
  // shifter control

  wire shifting = (state_q == ST_SHIFT);
  wire lead = ~edge_q[0];
  wire sample_edge = shifting && tick && (lead ^ cpha);
  wire setup_edge = shifting && tick && (lead ~^ cpha);
  wire last_edge = shifting && tick && (edge_q == `USSPI_EDGES);
  wire can_run = txen && (mspi || sync) && XCK_DIR;
  wire start_now = can_run && (txfull_q || wr_data) &&
    (!shifting || last_edge);
  wire [7:0] load_val = txfull_q ? txbuf_q : WDATA;
  wire [7:0] tx_next = dord ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
  wire [7:0] rx_next = dord ? {RXD, rx_sh_q[7:1]} : {rx_sh_q[6:0], RXD};
  wire rx_push = last_edge && rxen;
  wire rx_pop = rd_data && receive_complete_flag;

  // only a low-byte write takes the divisor from the bus; otherwise the
  // stored value; a low-byte write reloads the count at once, even in a running frame
  wire [11:0] div_now = wr_blo ? {baud_q[11:8], WDATA} : baud_q;
  usspi_baud u_baud (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .CE(CE),
    .RUN(shifting),
    .RELOAD(wr_blo),
    .DIVISOR(div_now),
    .TICK(tick)
  );

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      edge_q <= 4'h0;
      sck_q <= 1'b0;
      txd_q <= 1'b1;
      txfull_q <= 1'b0;
      txbuf_q <= 8'h00;
      txc_q <= 1'b0;
    end else if (CE) begin
      // transmit buffer: second level in front of the shifter
      if (start_now && !(wr_data && txfull_q)) begin
        txfull_q <= 1'b0;
      end else if (wr_data) begin
        txfull_q <= 1'b1;
      end
      if (wr_data) begin
        txbuf_q <= WDATA;
      end
      if (last_edge) begin
        txc_q <= 1'b1;
      end else if (wr_a && WDATA[`USSPI_A_TXC]) begin
        txc_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          sck_q <= cpol;
          edge_q <= 4'h0;
          if (start_now) begin
            state_q <= ST_SHIFT;
            tx_sh_q <= load_val;
            txd_q <= dord ? load_val[0] : load_val[7];
          end else begin
            txd_q <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sck_q <= ~sck_q;
            edge_q <= edge_q + 4'h1;
          end
          if (sample_edge) begin
            rx_sh_q <= rx_next;
          end
          if (setup_edge && (edge_q != 4'h0) && !last_edge) begin
            tx_sh_q <= tx_next;
            txd_q <= dord ? tx_next[0] : tx_next[7];
          end
          if (last_edge) begin
            edge_q <= 4'h0;
            if (start_now) begin
              tx_sh_q <= load_val;
              txd_q <= dord ? load_val[0] : load_val[7];
            end else begin
              state_q <= ST_IDLE;
              txd_q <= 1'b1;
            end
          end
          if (!can_run) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer, two entries; on overflow the newest byte is lost

  // phase 0 ends on a setup edge: the byte is already whole in the shifter
  wire [7:0] rx_byte = sample_edge ? rx_next : rx_sh_q;
  wire do_push = rx_push && (rx_cnt_q != 2'h2 || rx_pop);

  genvar gi;
  generate
    for (gi = 0; gi < `USSPI_RX_DEPTH; gi = gi + 1) begin : g_rx
      always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          rxbuf_q[gi] <= 8'h00;
        end else if (CE && do_push && (wr_ptr_q == gi)) begin
          rxbuf_q[gi] <= rx_byte;
        end
      end
    end
  endgenerate

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else if (CE) begin
      if (!rxen) begin
        rd_ptr_q <= 1'b0;
        wr_ptr_q <= 1'b0;
        rx_cnt_q <= 2'h0;
      end else begin
        if (do_push) begin
          wr_ptr_q <= ~wr_ptr_q;
        end
        if (rx_pop) begin
          rd_ptr_q <= ~rd_ptr_q;
        end
        if (do_push && !rx_pop) begin
          rx_cnt_q <= rx_cnt_q + 2'h1;
        end else if (rx_pop && !do_push) begin
          rx_cnt_q <= rx_cnt_q - 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start-frame detector

  wire sd_active = !mspi;
  wire start_cond = sd_active && start_frame_detect_enable && rxd_prev_q && !RXD;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rxd_prev_q <= 1'b1;
      rxs_q <= 1'b0;
    end else if (CE) begin
      rxd_prev_q <= RXD;
      if (start_cond) begin
        rxs_q <= 1'b1;
      end else if (wr_sd && WDATA[`USSPI_SD_RXS]) begin
        rxs_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes and reads

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      baud_q <= `USSPI_RST_BAUD;
      sdctrl_q <= `USSPI_RST_SDCTRL;
      ctrl_c_q <= `USSPI_RST_CTRL_C;
      ctrl_b_q <= `USSPI_RST_CTRL_B;
      RDATA <= 8'h00;
    end else if (CE) begin
      if (wr_blo) begin
        baud_q[7:0] <= WDATA;
      end
      if (wr_bhi) begin
        baud_q[11:8] <= WDATA[3:0];
      end
      if (wr_sd) begin
        sdctrl_q <= {WDATA[7], 1'b0, WDATA[5], 5'h00};
      end
      if (wr_c) begin
        ctrl_c_q <= WDATA;
      end
      if (wr_b) begin
        ctrl_b_q <= {WDATA[7:3], 3'h0};
      end
      if (RD) begin
        case (ADDR)
          `USSPI_OFS_DATA: RDATA <= receive_complete_flag ? rxbuf_q[rd_ptr_q] : 8'h00;
          `USSPI_OFS_BAUD_LO: RDATA <= baud_q[7:0];
          `USSPI_OFS_BAUD_HI: RDATA <= {4'h0, baud_q[11:8]};
          `USSPI_OFS_SDCTRL: RDATA <= {sdctrl_q[7], rxs_q, sdctrl_q[5],
            5'h00};
          `USSPI_OFS_CTRL_C: RDATA <= ctrl_c_q;
          `USSPI_OFS_CTRL_B: RDATA <= ctrl_b_q;
          `USSPI_OFS_STAT_A: RDATA <= {receive_complete_flag, txc_q, ~txfull_q, 5'h00};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins, interrupt requests and wake

  assign XCK_O = sck_q;
  assign XCK_OE_N = ~XCK_DIR;
  assign TXD = txd_q;
  assign IRQ_RX_START = receive_start_irq_enable && GIE && rxs_q && sd_active;
  assign IRQ_RX_DONE = ctrl_b_q[`USSPI_B_RXCIE] && GIE && receive_complete_flag;
  assign IRQ_TX_DONE = ctrl_b_q[`USSPI_B_TXCIE] && GIE && txc_q;
  assign IRQ_DATA_EMPTY = ctrl_b_q[`USSPI_B_UDRIE] && GIE && !txfull_q;
  assign WAKE = sd_active && start_frame_detect_enable &&
    ((receive_start_irq_enable && rxs_q) || (ctrl_b_q[`USSPI_B_RXCIE] && receive_complete_flag));

endmodule // usspi_core
`default_nettype wire

/* File: verification/usspi_slave.sv */
// SPI slave model: samples serial out, returns a preloaded byte
`timescale 1ns/1ns
`default_nettype none
module usspi_slave (
  input wire xck, // transfer clock
  input wire mosi, // data from master
  input wire cpol, // idle clock level
  input wire cpha, // clock phase
  input wire ld, // rising edge loads reply
  input wire [7:0] ld_byte, // reply byte
  output wire miso, // data to master
  output wire [7:0] rx_byte // last eight bits taken
);
  reg [7:0] sr_q = 8'h00;
  reg [7:0] rx_q = 8'h00;
  reg first_q = 1'b0;
  // hold time: the line is taken as it stood just before the clock edge
  wire #1 mosi_h = mosi;
  // line shows the inverse until the first phase-1 setup edge
  assign miso = (cpha && first_q) ? ~sr_q[7] : sr_q[7];
  assign rx_byte = rx_q;
  always @(posedge ld) begin
    sr_q = ld_byte;
    first_q = 1'b1;
  end
  always @(xck) begin
    if ((xck != cpol) == !cpha) begin
      rx_q = {rx_q[6:0], mosi_h};
    end else if (cpha && first_q) begin
      first_q = 1'b0;
    end else begin
      sr_q = {sr_q[6:0], ~sr_q[0]};
    end
  end
endmodule // usspi_slave
`default_nettype wire

/* File: verification/usspi_core_sva.sv */
// checker: assertions on the serial port core pins
`timescale 1ns/1ns
`default_nettype none
module usspi_core_sva (
  input wire CLK, // clock
  input wire RESET_N, // reset
  input wire CE, // enable
  input wire [7:0] ADDR, // address
  input wire [7:0] WDATA, // write data
  input wire WR, // write
  input wire RD, // read
  input wire [7:0] RDATA, // read data
  input wire GIE, // global irq enable
  input wire XCK_DIR, // clock direction
  input wire XCK_O, // clock out
  input wire XCK_OE_N, // clock out enable
  input wire RXD, // serial in
  input wire IRQ_RX_START // start irq
);
  reg [11:0] div_q;
  reg [13:0] ecnt_q;
  reg [1:0] mode_q, age_q;
  reg sie_q, start_frame_detect_enable_q, cpol_q, xq_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  //////////////////////////////////////////////////////////////////////////
  // mirror of control fields; ecnt_q counts cycles since the clock moved
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= 12'h000;
      ecnt_q <= 14'h0000;
      mode_q <= 2'h0;
      age_q <= 2'h3;
      {sie_q, start_frame_detect_enable_q, cpol_q, xq_q} <= 4'h0;
    end else begin
      xq_q <= XCK_O;
      ecnt_q <= (XCK_O != xq_q) ? 14'h0000 : ecnt_q + {13'h0000, ~&ecnt_q};
      if (age_q != 2'h3) age_q <= age_q + 2'h1;
      if (WR && CE) begin
        case (ADDR)
          8'h09: div_q[7:0] <= WDATA;
          8'h0a: div_q[11:8] <= WDATA[3:0];
          8'h0b: {sie_q, start_frame_detect_enable_q} <= {WDATA[7], WDATA[5]};
          8'h0c: begin
            mode_q <= WDATA[7:6];
            cpol_q <= WDATA[0];
            age_q <= 2'h0;
          end
          default: ;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_oe_follows: assert property (XCK_OE_N == !XCK_DIR)
    else $error("clock enable does not follow direction");
  a_irq_gate: assert property (IRQ_RX_START |-> GIE && sie_q)
    else $error("start irq without both enables");
  a_mode_blocks: assert property (mode_q == 2'h3 |-> !IRQ_RX_START)
    else $error("start irq in master SPI mode");
  a_start_sets: assert property (start_frame_detect_enable_q && sie_q && GIE &&
    mode_q != 2'h3 && $fell(RXD) |-> ##[1:3] IRQ_RX_START)
    else $error("start condition not flagged");
  a_hi_nibble: assert property (CE && RD && ADDR == 8'h0a
    |=> RDATA[7:4] == 4'h0) else $error("divisor high byte too wide");
  a_unmapped_zero: assert property (CE && RD &&
    (ADDR < 8'h08 || ADDR > 8'h0e) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_half_period: assert property (XCK_O != xq_q && age_q == 2'h3
    |-> ecnt_q >= {2'b00, div_q}) else $error("clock half period short");
  a_idle_level: assert property (age_q == 2'h3 &&
    ecnt_q > {1'b0, div_q, 1'b0} + 14'd4 |-> xq_q == cpol_q)
    else $error("clock not at idle level");
  c_edge: cover property (XCK_O != xq_q && cpol_q);
  c_start: cover property (IRQ_RX_START);
  c_blocked: cover property (mode_q == 2'h3 && $fell(RXD));
endmodule // usspi_core_sva
bind usspi_core usspi_core_sva i_usspi_core_sva (.CLK, .RESET_N, .CE,
  .ADDR, .WDATA, .WR, .RD, .RDATA, .GIE, .XCK_DIR, .XCK_O, .XCK_OE_N,
  .RXD, .IRQ_RX_START);
`default_nettype wire

/* File: verification/tb_top.sv */
// testbench: registers, start detector and SPI frames with a slave model
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  reg CLK = 1'b0, RESET_N = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0;
  reg GIE = 1'b0, XCK_DIR = 1'b0, rxd_tb = 1'b1, use_sl = 1'b0;
  reg ld = 1'b0, cpol = 1'b0, cpha = 1'b0, lsb;
  reg [7:0] ADDR = 8'h00, WDATA = 8'h00, ld_byte = 8'h00, v, tx, rb, dv;
  reg [7:0] exp_q[$];
  wire [7:0] RDATA, sl_rx;
  wire XCK_O, XCK_OE_N, TXD, IRQ_RX_START, miso, irq_rd, irq_td, irq_de;
  wire wake;
  wire RXD = use_sl ? miso : rxd_tb;
  integer seed = 77781, bad_count = 0, compares = 0, cyc = 0, i, k, n;
  usspi_core i_usspi_core (.CLK, .RESET_N, .CE, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .GIE, .XCK_DIR, .XCK_O, .XCK_OE_N, .TXD, .RXD, .IRQ_RX_START,
    .IRQ_RX_DONE(irq_rd), .IRQ_TX_DONE(irq_td), .IRQ_DATA_EMPTY(irq_de),
    .WAKE(wake));
  usspi_slave i_usspi_slave (.xck(XCK_O), .mosi(TXD), .cpol, .cpha, .ld,
    .ld_byte, .miso, .rx_byte(sl_rx));
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 v = RDATA;
    end
  endtask
  function [7:0] rev(input [7:0] b);
    integer j;
    begin
      for (j = 0; j < 8; j++) rev[j] = b[7-j];
    end
  endfunction
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(8'h09 + i[7:0]);
      `CHK("reset value", (i == 3) ? 8'h06 : 8'h00, v)
    end
    rd(8'h20);
    `CHK("unmapped", 8'h00, v)
    wr(8'h0a, 8'hff);
    rd(8'h0a);
    `CHK("divisor high", 8'h0f, v)
    wr(8'h0a, 8'h00);
    CE <= 1'b0;
    wr(8'h0a, 8'h05);
    CE <= 1'b1;
    rd(8'h0a);
    `CHK("frozen write", 8'h00, v)
    wr(8'h0b, 8'ha0);
    GIE <= 1'b1;
    // k 0: irq on; k 1: global off; k 2: master SPI mode blocks detector
    for (k = 0; k < 3; k++) begin
      if (k == 1) GIE <= 1'b0;
      if (k == 2) wr(8'h0c, 8'hc0);
      @(posedge CLK) rxd_tb <= 1'b0;
      repeat (4) @(posedge CLK);
      #1 `CHK("start irq", k == 0, IRQ_RX_START)
      rd(8'h0b);
      `CHK("start flag", (k == 2) ? 8'ha0 : 8'he0, v)
      wr(8'h0b, 8'he0);
      rxd_tb <= 1'b1;
    end
    XCK_DIR <= 1'b1;
    GIE <= 1'b1;
    wr(8'h0d, 8'hf8);
    use_sl <= 1'b1;
    // i 0 to 7: master SPI modes 0 to 3; i 8, 9: synchronous, LSB first
    for (i = 0; i < 10; i++) begin
      tx = 8'($random(seed));
      rb = 8'($random(seed));
      lsb = 1'($random(seed)) | (i > 7);
      dv = 8'($random(seed)) & 8'h03;
      {cpha, cpol} <= {i[1] | (i > 7), i[0]};
      exp_q.push_back(lsb ? rev(rb) : rb);
      wr(8'h09, dv);
      wr(8'h0c, {(i > 7) ? 2'b01 : 2'b11, 3'b000, lsb, i[1:0]});
      repeat (2) @(posedge CLK);
      ld_byte = rb;
      ld <= 1'b1;
      @(posedge CLK);
      ld <= 1'b0;
      wr(8'h0e, 8'h40);
      wr(8'h08, tx);
      v = 8'h00;
      n = 0;
      while (!v[7] && n < 200) begin
        rd(8'h0e);
        n++;
      end
      `CHK("slave got", lsb ? rev(tx) : tx, sl_rx)
      `CHK("rx done irq", 1'b1, irq_rd)
      `CHK("tx done irq", 1'b1, irq_td)
      `CHK("data empty irq", 1'b1, irq_de)
      `CHK("wake", i > 7, wake)
      rd(8'h08);
      rb = exp_q.pop_front();
      `CHK("master got", rb, v)
      `CHK("rx done irq", 1'b0, irq_rd)
    end
    summarize;
  end
endmodule // tb_top
`default_nettype wire
